// *** fwcc_top.sv ***
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - data lines carry valid and modified bits; invalid lines ignored in lookup.
// - instruction lines are only valid or invalid; no processor writes reach them.
// - reset disables caching and clears the whole control register.
// - reset leaves line state bits alone; software invalidates before enabling.
// - data set index is address bits 10 to 4, 128 sets.
// - hit needs tag match on bits 31 to 11 plus valid bit.
// - allocation takes the lowest numbered invalid way first.
// - with all ways valid a 2-bit counter picks, advancing per allocation.
// - half lock confines replacement to ways 2 and 3.
// - clean victims are invalidated; modified victims go to push buffer first.
// - allocation writes tag, fills line, then sets valid.
// - read misses allocate; write misses allocate only in copyback regions.
// - copyback write miss fills, sets valid and modified, merges without memory write.
// - read hit returns data and changes no state or replacement.
// - write hit updates bytes; write-through writes out, copyback sets modified.
// - accesses that cross a longword boundary split into two cache accesses.
// - valid only per whole line, set after complete fill.
// - line fill starts at requested longword and forwards it at once.
// - inhibited accesses bypass the cache to the external bus.
// - inhibited normal instruction reads with fill buffer enabled use the fill buffer.
// - inhibited accesses never push or invalidate matching lines.
// - mode and write protect come from matching region register or defaults.
// - lines are 16 bytes, four longwords; data cache 128 sets by four ways.
// - instruction cache has 256 sets, index one bit wider.
module fwcc_top
  import fwcc_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_req_valid,
  input  wire logic        i_req_instr,
  input  wire logic        i_req_write,
  input  wire logic [31:0] i_req_addr,
  input  wire logic [1:0]  i_req_size,
  input  wire logic [1:0]  i_req_transfer_type,
  input  wire logic [31:0] i_req_wdata,
  output logic             o_req_ready,
  output logic             o_rsp_valid,
  output logic             o_rsp_err,
  output logic      [31:0] o_rsp_data,
  output logic             o_bus_req,
  output logic             o_bus_write,
  output logic             o_bus_line,
  output logic      [31:0] o_bus_addr,
  output logic      [3:0]  o_bus_be,
  output logic      [31:0] o_bus_wdata,
  input  wire logic        i_bus_ack,
  input  wire logic [31:0] i_bus_rdata
);
  default clocking cb_core @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  fwcc_state_type state_reg, state_next;
  logic [31:0] cache_control_reg;
  logic [31:0] access_control_reg [2];
  logic [31:0] addr_reg;
  logic [7:0]  be8_reg;
  logic [63:0] wd64_reg, rd64_reg;
  logic [1:0]  tt_reg, d_cnt, i_cnt, beat_reg, fl_crit, fl_way;
  logic        instr_reg, write_reg, two_reg, pass_reg;
  logic        rsp_valid_reg, rsp_err_reg, rsp_sent_reg;
  logic        fl_i, fl_fb, fb_valid_reg, pb_valid_reg;
  logic [27:0] fl_line, fb_line, pb_line;
  logic [31:0] fb_data [LWS];
  logic [31:0] pb_data [LWS];

  // line storage; state bits deliberately have no reset
  logic [31:0] d_data [DSETS*WAYS*LWS];
  logic [31:0] i_data [ISETS*WAYS*LWS];
  logic [20:0] d_tag  [DSETS*WAYS];
  logic [20:0] i_tag  [ISETS*WAYS];
  logic [3:0]  d_val  [DSETS];
  logic [3:0]  d_mod  [DSETS];
  logic [3:0]  i_val  [ISETS];

  // register bus decode
  wire        apb_acc = i_psel & i_penable;
  wire        apb_wr  = apb_acc & i_pwrite;
  wire        sel_cc  = i_paddr == OFS_CC;
  wire        sel_a0  = i_paddr == OFS_AC0;
  wire        sel_a1  = i_paddr == OFS_AC1;
  wire        sel_st  = i_paddr == OFS_STAT;
  wire        inv_d   = apb_wr & sel_cc & i_pwdata[CC_DINV];
  wire        inv_i   = apb_wr & sel_cc & i_pwdata[CC_IINV];
  wire [31:0] status_word = {23'h000000, state_reg, pb_valid_reg, fb_valid_reg, i_cnt, d_cnt};

  assign o_pready  = 1'b1;
  assign o_pslverr = apb_acc & ~(sel_cc | sel_a0 | sel_a1 | sel_st);
  assign o_prdata  = sel_cc ? cache_control_reg :
                     sel_a0 ? access_control_reg[0] :
                     sel_a1 ? access_control_reg[1] :
                     sel_st ? status_word : 32'h0000_0000;

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cache_control_reg     <= CC_RST;
      access_control_reg[0] <= AC_RST;
      access_control_reg[1] <= AC_RST;
    end else if (apb_wr) begin
      if (sel_cc) begin
        cache_control_reg          <= i_pwdata;
        cache_control_reg[CC_DINV] <= 1'b0;
        cache_control_reg[CC_IINV] <= 1'b0;
      end
      if (sel_a0) access_control_reg[0] <= i_pwdata;
      if (sel_a1) access_control_reg[1] <= i_pwdata;
    end
  end

  a_reset_clear: assert property ($past(i_sys_rst) |-> cache_control_reg == CC_RST)
    else $error("control register not clear after reset");

  // request capture and split into longword passes
  wire [3:0]  size_mask = i_req_size == SZ_BYTE ? 4'h1 : i_req_size == SZ_WORD ? 4'h3 : 4'hF;
  wire [7:0]  req_be8   = {4'h0, size_mask} << i_req_addr[1:0];
  wire [63:0] req_wd64  = {32'h0000_0000, i_req_wdata} << {i_req_addr[1:0], 3'b000};
  wire        acc       = i_req_valid & (state_reg == ST_IDLE);
  wire        more      = two_reg & ~pass_reg;
  wire [29:0] cur_lw    = addr_reg[31:2] + {29'h0000000, pass_reg};
  wire [31:0] cur_addr  = {cur_lw, 2'b00};
  wire [3:0]  cur_be    = pass_reg ? be8_reg[7:4] : be8_reg[3:0];
  wire [31:0] cur_wd    = pass_reg ? wd64_reg[63:32] : wd64_reg[31:0];
  wire [63:0] rsp64     = rd64_reg >> {addr_reg[1:0], 3'b000};

  // lookup
  wire [6:0]  set_d = cur_addr[10:4];
  wire [7:0]  set_i = cur_addr[11:4];
  wire [20:0] tag   = cur_addr[31:11];
  wire [1:0]  lwi   = cur_addr[3:2];
  logic [3:0] dhit, ihit;
  for (genvar w = 0; w < WAYS; w++) begin : g_way
    assign dhit[w] = d_val[set_d][w] & (d_tag[{set_d, 2'(w)}] == tag);
    assign ihit[w] = i_val[set_i][w] & (i_tag[{set_i, 2'(w)}] == tag);
  end
  wire [3:0] hitv    = instr_reg ? ihit : dhit;
  wire       hit     = |hitv;
  wire [1:0] hit_way = hitv[0] ? 2'h0 : hitv[1] ? 2'h1 : hitv[2] ? 2'h2 : 2'h3;
  wire [3:0] vv      = instr_reg ? i_val[set_i] : d_val[set_d];
  wire       all_valid = &vv;
  wire [1:0] inv_way = !vv[0] ? 2'h0 : !vv[1] ? 2'h1 : !vv[2] ? 2'h2 : 2'h3;
  wire       lock    = instr_reg ? cache_control_reg[CC_ILCK] : cache_control_reg[CC_DLCK];
  wire [1:0] cnt     = instr_reg ? i_cnt : d_cnt;
  wire [1:0] victim  = !all_valid ? inv_way : lock ? {1'b1, cnt[0]} : cnt;
  wire       vic_mod = !instr_reg & vv[victim] & d_mod[set_d][victim];

  // region attributes
  logic [1:0] acr_hit;
  for (genvar a = 0; a < 2; a++) begin : g_acr
    assign acr_hit[a] = access_control_reg[a][AC_EN] &
      (((cur_addr[31:24] ^ access_control_reg[a][AC_BASE +: 8]) &
        ~access_control_reg[a][AC_MASK +: 8]) == 8'h00);
  end
  wire [1:0] def_mode = instr_reg ? cache_control_reg[CC_IDM +: 2] : cache_control_reg[CC_DDM +: 2];
  wire [1:0] mode = acr_hit[0] ? access_control_reg[0][AC_MODE +: 2] :
                    acr_hit[1] ? access_control_reg[1][AC_MODE +: 2] : def_mode;
  wire       wprot = acr_hit[0] ? access_control_reg[0][AC_WP] :
                     acr_hit[1] ? access_control_reg[1][AC_WP] : cache_control_reg[CC_DWP];
  wire       en = instr_reg ? cache_control_reg[CC_IEN] : cache_control_reg[CC_DEN];
  wire       cacheable = en & ~mode[1];
  wire       copyback  = mode == MODE_CB;
  wire       wp_fault  = write_reg & wprot;
  wire       fb_case   = ~cacheable & instr_reg & cache_control_reg[CC_IFB] &
                         (tt_reg == TT_NORMAL);
  wire       fb_hit    = fb_case & fb_valid_reg & (fb_line == cur_addr[31:4]);

  // decisions in the lookup cycle
  wire look     = (state_reg == ST_LOOK) & ~wp_fault;
  wire alloc_go = look & cacheable & ~hit & (~write_reg | copyback);
  wire push_go  = alloc_go & vic_mod;
  wire fill_go  = alloc_go | (look & fb_case & ~fb_hit);
  wire whit_go  = look & cacheable & hit & write_reg;
  wire sgl_go   = look & ((~cacheable & ~fb_case) |
                          (cacheable & write_reg & ~copyback));
  wire rd_go    = look & ((cacheable & hit & ~write_reg) | fb_hit);
  wire [31:0] rd_word = fb_hit    ? fb_data[lwi] :
                        instr_reg ? i_data[{set_i, hit_way, lwi}] : d_data[{set_d, hit_way, lwi}];

  // bus beats
  wire       beat_last = i_bus_ack & (beat_reg == BEAT_LAST);
  wire [1:0] fl_lw     = fl_crit + beat_reg;
  wire       fwd       = (state_reg == ST_FILL) & i_bus_ack & (beat_reg == 2'h0) & ~write_reg;
  wire       fin = (look & ~fill_go & ~sgl_go) |
                   ((state_reg == ST_SGL) & i_bus_ack) |
                   ((state_reg == ST_FILL) & beat_last & ~pb_valid_reg & ~write_reg) |
                   ((state_reg == ST_PUSH) & beat_last & ~write_reg);
  wire       err_go = (state_reg == ST_LOOK) & wp_fault;
  fwcc_state_type after;
  assign after = more ? ST_LOOK : ST_IDLE;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (acc) state_next = ST_LOOK;
      ST_LOOK: begin
        if (wp_fault) state_next = ST_IDLE;
        else if (fill_go) state_next = ST_FILL;
        else if (sgl_go) state_next = ST_SGL;
        else state_next = after;
      end
      ST_FILL: if (beat_last) state_next = pb_valid_reg ? ST_PUSH : write_reg ? ST_LOOK : after;
      ST_PUSH: if (beat_last) state_next = write_reg ? ST_LOOK : after;
      ST_SGL:  if (i_bus_ack) state_next = after;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= ST_IDLE;
      addr_reg  <= 32'h0000_0000;
      be8_reg   <= 8'h00;
      wd64_reg  <= 64'h0;
      tt_reg    <= 2'h0;
      instr_reg <= 1'b0;
      write_reg <= 1'b0;
      two_reg   <= 1'b0;
      pass_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (acc) begin
        addr_reg  <= i_req_addr;
        be8_reg   <= req_be8;
        wd64_reg  <= req_wd64;
        tt_reg    <= i_req_transfer_type;
        instr_reg <= i_req_instr;
        write_reg <= i_req_write & ~i_req_instr;
        two_reg   <= |req_be8[7:4];
        pass_reg  <= 1'b0;
      end else if (fin & more) begin
        pass_reg <= 1'b1;
      end
    end
  end

  a_split_pass: assert property (acc && (|req_be8[7:4]) |=> two_reg && !pass_reg)
    else $error("misaligned access not split");

  // response
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rsp_valid_reg <= 1'b0;
      rsp_err_reg   <= 1'b0;
      rsp_sent_reg  <= 1'b0;
      rd64_reg      <= 64'h0;
    end else begin
      rsp_valid_reg <= err_go | (fwd & ~more) | (fin & ~more & ~rsp_sent_reg);
      rsp_err_reg   <= err_go;
      if (acc) rsp_sent_reg <= 1'b0;
      else if (fwd & ~more) rsp_sent_reg <= 1'b1;
      if (rd_go) rd64_reg[{pass_reg, 5'h00} +: 32] <= rd_word;
      else if (fwd | ((state_reg == ST_SGL) & i_bus_ack & ~write_reg))
        rd64_reg[{pass_reg, 5'h00} +: 32] <= i_bus_rdata;
    end
  end

  assign o_req_ready = state_reg == ST_IDLE;
  assign o_rsp_valid = rsp_valid_reg;
  assign o_rsp_err   = rsp_err_reg;
  assign o_rsp_data  = rsp64[31:0];

  a_crit_forward: assert property (fwd && !more |=> o_rsp_valid && !o_rsp_err)
    else $error("critical longword not forwarded");

  // fill, push and replacement control
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      d_cnt        <= 2'h0;
      i_cnt        <= 2'h0;
      beat_reg     <= 2'h0;
      fl_line      <= 28'h0;
      fl_crit      <= 2'h0;
      fl_way       <= 2'h0;
      fl_i         <= 1'b0;
      fl_fb        <= 1'b0;
      fb_valid_reg <= 1'b0;
      fb_line      <= 28'h0;
      pb_valid_reg <= 1'b0;
      pb_line      <= 28'h0;
    end else begin
      if (alloc_go & instr_reg) i_cnt <= i_cnt + 2'h1;
      if (alloc_go & ~instr_reg) d_cnt <= d_cnt + 2'h1;
      if (fill_go) begin
        beat_reg <= 2'h0;
        fl_line  <= cur_addr[31:4];
        fl_crit  <= lwi;
        fl_way   <= victim;
        fl_i     <= instr_reg;
        fl_fb    <= fb_case;
        fb_line  <= cur_addr[31:4];
      end else if (i_bus_ack & ((state_reg == ST_FILL) | (state_reg == ST_PUSH))) begin
        beat_reg <= beat_reg + 2'h1;
      end
      if (inv_d | inv_i | fill_go) fb_valid_reg <= 1'b0;
      else if ((state_reg == ST_FILL) & beat_last & fl_fb) fb_valid_reg <= 1'b1;
      if (push_go) begin
        pb_valid_reg <= 1'b1;
        pb_line      <= {d_tag[{set_d, victim}], set_d};
      end else if ((state_reg == ST_PUSH) & beat_last) begin
        pb_valid_reg <= 1'b0;
      end
    end
  end

  a_invalid_first: assert property (alloc_go && !all_valid |->
      !vv[victim] && (victim == 2'h0 || vv[0]))
    else $error("valid way chosen while an invalid way exists");

  a_half_lock: assert property (alloc_go && all_valid && lock |-> victim[1])
    else $error("locked way chosen for replacement");

  a_round_robin: assert property (alloc_go && !instr_reg |=> d_cnt == $past(d_cnt) + 2'h1)
    else $error("replacement counter did not advance");

  a_push_first: assert property (push_go |=> pb_valid_reg ##1 !o_bus_write [*3])
    else $error("push buffer not loaded before fill");

  // line arrays; no reset so power-up state survives reset
  always_ff @(posedge i_core_clk) begin
    if (alloc_go & instr_reg) begin
      i_val[set_i][victim]       <= 1'b0;
      i_tag[{set_i, victim}]     <= tag;
    end
    if (alloc_go & ~instr_reg) begin
      d_val[set_d][victim]       <= 1'b0;
      d_mod[set_d][victim]       <= 1'b0;
      d_tag[{set_d, victim}]     <= tag;
    end
    if (push_go)
      for (int k = 0; k < LWS; k++) pb_data[k] <= d_data[{set_d, victim, 2'(k)}];
    if ((state_reg == ST_FILL) & i_bus_ack) begin
      if (fl_fb) fb_data[fl_lw] <= i_bus_rdata;
      else if (fl_i) i_data[{fl_line[7:0], fl_way, fl_lw}] <= i_bus_rdata;
      else d_data[{fl_line[6:0], fl_way, fl_lw}] <= i_bus_rdata;
      if (beat_last & ~fl_fb & fl_i) i_val[fl_line[7:0]][fl_way] <= 1'b1;
      if (beat_last & ~fl_fb & ~fl_i) d_val[fl_line[6:0]][fl_way] <= 1'b1;
    end
    if (whit_go) begin
      for (int b = 0; b < 4; b++)
        if (cur_be[b]) d_data[{set_d, hit_way, lwi}][8*b +: 8] <= cur_wd[8*b +: 8];
      if (copyback) d_mod[set_d][hit_way] <= 1'b1;
    end
    if (inv_d)
      for (int s = 0; s < DSETS; s++) begin
        d_val[s] <= 4'h0;
        d_mod[s] <= 4'h0;
      end
    if (inv_i)
      for (int s = 0; s < ISETS; s++) i_val[s] <= 4'h0;
  end

  a_fill_not_valid: assert property ((state_reg == ST_FILL) && !fl_fb && !fl_i |->
      !d_val[fl_line[6:0]][fl_way])
    else $error("line valid before fill completed");

  a_cb_write_mod: assert property (whit_go && copyback && !inv_d |=>
      d_mod[$past(set_d)][$past(hit_way)] && !o_bus_req)
    else $error("copyback write hit did not set modified");

  a_read_hit_calm: assert property (rd_go && !fb_hit |=>
      state_reg != ST_FILL && $stable(d_cnt) && $stable(i_cnt))
    else $error("read hit disturbed line state");

  a_wt_miss_bus: assert property (look && cacheable && !copyback && write_reg && !hit |=>
      state_reg == ST_SGL && o_bus_write && !o_bus_line)
    else $error("write-through miss did not go to the bus");

  a_inh_bypass: assert property (look && !cacheable && !fb_case |=>
      state_reg == ST_SGL && !o_bus_line)
    else $error("inhibited access did not bypass");

  a_inval_all: assert property (inv_d |=> d_val[$past(set_d)] == 4'h0)
    else $error("invalidate-all left a valid line");

  // system bus
  assign o_bus_req   = (state_reg == ST_FILL) | (state_reg == ST_PUSH) | (state_reg == ST_SGL);
  assign o_bus_line  = (state_reg == ST_FILL) | (state_reg == ST_PUSH);
  assign o_bus_write = (state_reg == ST_PUSH) | ((state_reg == ST_SGL) & write_reg);
  assign o_bus_addr  = (state_reg == ST_FILL) ? {fl_line, fl_lw, 2'b00} :
                       (state_reg == ST_PUSH) ? {pb_line, beat_reg, 2'b00} : cur_addr;
  assign o_bus_be    = (state_reg == ST_SGL) ? cur_be : 4'hF;
  assign o_bus_wdata = (state_reg == ST_PUSH) ? pb_data[beat_reg] : cur_wd;
endmodule : fwcc_top

// *** fwcc_pkg.sv ***
package fwcc_pkg;
  localparam int unsigned WAYS  = 4;
  localparam int unsigned LWS   = 4;
  localparam int unsigned DSETS = 128;
  localparam int unsigned ISETS = 256;

  localparam logic [7:0]  OFS_CC   = 8'h00;
  localparam logic [7:0]  OFS_AC0  = 8'h04;
  localparam logic [7:0]  OFS_AC1  = 8'h08;
  localparam logic [7:0]  OFS_STAT = 8'h0C;
  localparam logic [31:0] CC_RST   = 32'h0000_0000;
  localparam logic [31:0] AC_RST   = 32'h0000_0000;

  // cache_control_reg fields
  localparam int CC_DEN  = 0;
  localparam int CC_DLCK = 1;
  localparam int CC_DINV = 2;
  localparam int CC_IFB  = 4;
  localparam int CC_DDM  = 5;
  localparam int CC_DWP  = 7;
  localparam int CC_IEN  = 8;
  localparam int CC_ILCK = 9;
  localparam int CC_IINV = 10;
  localparam int CC_IDM  = 11;

  // access_control_reg fields
  localparam int AC_WP   = 2;
  localparam int AC_MODE = 5;
  localparam int AC_EN   = 15;
  localparam int AC_MASK = 16;
  localparam int AC_BASE = 24;

  localparam logic [1:0] MODE_WT    = 2'h0;
  localparam logic [1:0] MODE_CB    = 2'h1;
  localparam logic [1:0] MODE_INH_P = 2'h2;
  localparam logic [1:0] MODE_INH_I = 2'h3;
  localparam logic [1:0] SZ_BYTE    = 2'h0;
  localparam logic [1:0] SZ_WORD    = 2'h1;
  localparam logic [1:0] TT_NORMAL  = 2'h0;
  localparam logic [1:0] BEAT_LAST  = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOOK = 3'b001,
    ST_FILL = 3'b010,
    ST_PUSH = 3'b011,
    ST_SGL  = 3'b100
  } fwcc_state_type;
endpackage : fwcc_pkg

// *** fwcc_bus_model.sv ***
`timescale 1ns/1ps
module fwcc_bus_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_bus_req,
  input  wire logic        i_bus_write,
  input  wire logic [31:0] i_bus_addr,
  input  wire logic [3:0]  i_bus_be,
  input  wire logic [31:0] i_bus_wdata,
  input  wire logic [3:0]  i_wait,
  output logic             o_bus_ack,
  output logic      [31:0] o_bus_rdata,
  output logic      [15:0] o_rd_beats,
  output logic      [15:0] o_wr_beats,
  output logic      [31:0] o_last_rd
);
  // memory survives reset so pushed lines can be read back later
  logic [31:0] mem [logic [29:0]];
  logic [31:0] word;
  logic [3:0]  cnt;
  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_bus_ack <= 1'h0;
      o_bus_rdata <= 32'h0;
      o_rd_beats <= 16'h0;
      o_wr_beats <= 16'h0;
      cnt <= 4'h0;
    end else if (o_bus_ack) begin
      o_bus_ack <= 1'h0;
      o_bus_rdata <= ~o_bus_rdata;
      cnt <= 4'h0;
    end else if (i_bus_req && cnt >= i_wait) begin
      o_bus_ack <= 1'h1;
      word = mem.exists(i_bus_addr[31:2]) ? mem[i_bus_addr[31:2]] : i_bus_addr ^ 32'h5A5A_A5A5;
      if (i_bus_write) begin
        for (int b = 0; b < 4; b++)
          if (i_bus_be[b]) word[8*b +: 8] = i_bus_wdata[8*b +: 8];
        mem[i_bus_addr[31:2]] = word;
        o_wr_beats <= o_wr_beats + 16'h1;
      end else begin
        o_bus_rdata <= word;
        o_rd_beats <= o_rd_beats + 16'h1;
        o_last_rd <= i_bus_addr;
      end
    end else begin
      // idle data toggles so stale values never look valid
      cnt <= i_bus_req ? cnt + 4'h1 : 4'h0;
      o_bus_rdata <= ~o_bus_rdata;
    end
  end
endmodule : fwcc_bus_model

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top
  import fwcc_pkg::*;
;
  typedef struct {logic [3:0] k; logic [31:0] a, d, q; logic [3:0] nr, nw;} fwcc_row_type;
  logic             clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwd = 32'h0, ra = 32'h0, rwd = 32'h0, got, q;
  logic             rv = 1'h0, ri = 1'h0, rw = 1'h0, err, busy;
  logic [1:0]       rsz = 2'h2, rtt = 2'h0;
  logic [3:0]       wt = 4'h0;
  logic [15:0]      r0, w0;
  logic [63:0]      mis;
  wire logic        pready, pslverr, rr, sv, se, breq, bwr, bline, back;
  wire logic [31:0] prdata, sd, baddr, bwd, brd, last_rd;
  wire logic [3:0]  bbe;
  wire logic [15:0] nrd, nwr;
  int               fails = 0, comparisons = 0, cyc = 0;
  fwcc_row_type     rows [$];

  fwcc_top DUT (.i_core_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_req_valid(rv), .i_req_instr(ri), .i_req_write(rw),
    .i_req_addr(ra), .i_req_size(rsz), .i_req_transfer_type(rtt), .i_req_wdata(rwd),
    .o_req_ready(rr), .o_rsp_valid(sv), .o_rsp_err(se), .o_rsp_data(sd), .o_bus_req(breq),
    .o_bus_write(bwr), .o_bus_line(bline), .o_bus_addr(baddr), .o_bus_be(bbe),
    .o_bus_wdata(bwd), .i_bus_ack(back), .i_bus_rdata(brd));
  fwcc_bus_model BUS (.i_core_clk(clk), .i_sys_rst(rst), .i_bus_req(breq), .i_bus_write(bwr),
    .i_bus_addr(baddr), .i_bus_be(bbe), .i_bus_wdata(bwd), .i_wait(wt), .o_bus_ack(back),
    .o_bus_rdata(brd), .o_rd_beats(nrd), .o_wr_beats(nwr), .o_last_rd(last_rd));

  always #2.5 clk = ~clk;

  function automatic logic [31:0] p(input logic [31:0] a);
    return a ^ 32'h5A5A_A5A5;
  endfunction : p

  task automatic tally_and_finish();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pen <= 1'h0;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    got = prdata;
    err = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask : apb

  // k: bit0 write, bit1 instruction, bit2 odd transfer type, bit3 byte size
  task automatic core(input logic [3:0] k, input logic [31:0] a, input logic [31:0] d);
    r0 = nrd;
    w0 = nwr;
    @(posedge clk);
    rv <= 1'h1;
    rw <= k[0];
    ri <= k[1];
    rtt <= {1'h0, k[2]};
    rsz <= k[3] ? 2'h0 : 2'h2;
    ra <= a;
    rwd <= d;
    @(negedge clk);
    while (rr !== 1'h1) @(negedge clk);
    @(posedge clk);
    rv <= 1'h0;
    @(negedge clk);
    while (sv !== 1'h1) @(negedge clk);
    got = sd;
    err = se;
    busy = breq;
    while (rr !== 1'h1) @(negedge clk);
  endtask : core

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      tally_and_finish();
    end
  end

  initial begin
    mis = {p(32'h0000_3004), p(32'h0000_3000)} >> 16;
    rows = '{
      '{4'h0, 32'h0000_1008, 32'h0, p(32'h0000_1008), 4'h4, 4'h0},
      '{4'h0, 32'h0000_1008, 32'h0, p(32'h0000_1008), 4'h0, 4'h0},
      '{4'h1, 32'h0000_1004, 32'h1234_5678, 32'h0, 4'h0, 4'h0},
      '{4'h9, 32'h0000_1004, 32'h0000_00EE, 32'h0, 4'h0, 4'h0},
      '{4'h0, 32'h0000_1004, 32'h0, 32'h1234_56EE, 4'h0, 4'h0},
      '{4'h1, 32'h0000_2000, 32'hCAFE_0001, 32'h0, 4'h4, 4'h0},
      '{4'h0, 32'h0000_2000, 32'h0, 32'hCAFE_0001, 4'h0, 4'h0},
      '{4'h0, 32'h0000_3000, 32'h0, p(32'h0000_3000), 4'h4, 4'h0},
      '{4'h0, 32'h0000_4000, 32'h0, p(32'h0000_4000), 4'h4, 4'h0},
      '{4'h0, 32'h0000_3002, 32'h0, mis[31:0], 4'h0, 4'h0},
      '{4'h0, 32'h0000_5000, 32'h0, p(32'h0000_5000), 4'h4, 4'h4},
      '{4'h0, 32'h0000_1004, 32'h0, 32'h1234_56EE, 4'h4, 4'h4},
      '{4'h0, 32'h0000_2000, 32'h0, 32'hCAFE_0001, 4'h4, 4'h0},
      '{4'h1, 32'h6000_0010, 32'h0BAD_F00D, 32'h0, 4'h0, 4'h1},
      '{4'h0, 32'h6000_0010, 32'h0, 32'h0BAD_F00D, 4'h4, 4'h0},
      '{4'h1, 32'h6000_0010, 32'h0000_00A5, 32'h0, 4'h0, 4'h1},
      '{4'h0, 32'h6000_0010, 32'h0, 32'h0000_00A5, 4'h0, 4'h0},
      '{4'h0, 32'h7000_0000, 32'h0, p(32'h7000_0000), 4'h1, 4'h0},
      '{4'h0, 32'h7000_0000, 32'h0, p(32'h7000_0000), 4'h1, 4'h0},
      '{4'h1, 32'h7000_0000, 32'h7777_0000, 32'h0, 4'h0, 4'h1},
      '{4'h2, 32'h0000_8010, 32'h0, p(32'h0000_8010), 4'h4, 4'h0},
      '{4'h3, 32'h0000_8010, 32'hFFFF_FFFF, 32'h0, 4'h0, 4'h0},
      '{4'h2, 32'h0000_8014, 32'h0, p(32'h0000_8014), 4'h0, 4'h0},
      '{4'h2, 32'h7000_0020, 32'h0, p(32'h7000_0020), 4'h4, 4'h0},
      '{4'h2, 32'h7000_0024, 32'h0, p(32'h7000_0024), 4'h0, 4'h0},
      '{4'h6, 32'h7000_0028, 32'h0, p(32'h7000_0028), 4'h1, 4'h0}};
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    apb(1'h0, OFS_CC, 32'h0);
    chk("control after reset", got, CC_RST);
    apb(1'h1, OFS_AC0, 32'h6000_8000);
    apb(1'h1, OFS_AC1, 32'h7000_8040);
    apb(1'h0, OFS_AC1, 32'h0);
    chk("region readback", got, 32'h7000_8040);
    apb(1'h1, OFS_CC, 32'h0000_0535);
    apb(1'h0, OFS_CC, 32'h0);
    chk("invalidate self clear", got, 32'h0000_0131);
    apb(1'h0, 8'h10, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    $display("register test done");
    foreach (rows[i]) begin
      core(rows[i].k, rows[i].a, rows[i].d);
      if (!rows[i].k[0]) chk("read data", got, rows[i].q);
      chk("fill beats", 32'(nrd - r0), 32'(rows[i].nr));
      chk("write beats", 32'(nwr - w0), 32'(rows[i].nw));
      $display("row %0d done", i);
    end
    wt <= 4'h3;
    core(4'h0, 32'h0000_9008, 32'h0);
    chk("critical data", got, p(32'h0000_9008));
    chk("forwarded early", {31'h0, busy}, 32'h1);
    chk("wrap order", last_rd, 32'h0000_9004);
    $display("critical word test done");
    wt <= 4'h0;
    apb(1'h1, OFS_CC, 32'h0000_01A1);
    core(4'h1, 32'h0000_1004, 32'h0);
    chk("protect error", {31'h0, err}, 32'h1);
    chk("protect no write", 32'(nwr - w0), 32'h0);
    $display("write protect test done");
    apb(1'h1, OFS_CC, 32'h0000_0121);
    core(4'h1, 32'h0000_1004, 32'h5555_AAAA);
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    apb(1'h0, OFS_CC, 32'h0);
    chk("control after rerun", got, CC_RST);
    apb(1'h1, OFS_CC, 32'h0000_0021);
    core(4'h0, 32'h0000_1004, 32'h0);
    chk("line kept", got, 32'h5555_AAAA);
    apb(1'h1, OFS_CC, 32'h0000_0025);
    core(4'h0, 32'h0000_1004, 32'h0);
    chk("after invalidate", got, 32'h1234_56EE);
    chk("refill beats", 32'(nrd - r0), 32'h4);
    $display("reset test done");
    apb(1'h1, OFS_CC, 32'h0000_0023);
    for (int j = 2; j < 6; j++) core(4'h0, 32'(j) << 12, 32'h0);
    core(4'h0, 32'h0000_1004, 32'h0);
    chk("locked way kept", 32'(nrd - r0), 32'h0);
    chk("locked way data", got, 32'h1234_56EE);
    $display("half lock test done");
    tally_and_finish();
  end
endmodule : tb_top
